// File: ros_consts.vh
// Constants for the relay output source select block.
`ifndef ROS_CONSTS_VH
`define ROS_CONSTS_VH

// Register byte addresses on the Wishbone bus.
`define ROS_ADDR_W 8
`define ROS_OFF_SOURCE 8'h00
`define ROS_OFF_LEVEL 8'h04
`define ROS_OFF_RESTART 8'h08
`define ROS_OFF_LOGIC_CMD 8'h0c
`define ROS_OFF_STATUS 8'h10
`define ROS_OFF_ACTIVE 8'h14

// Field widths and positions.
`define ROS_SEL_W 4
`define ROS_LEVEL_W 16
`define ROS_MEAS_W 16
`define ROS_TRIES_W 4
`define ROS_CMD_W 16
`define ROS_CMD_RELAY_BIT 6
`define ROS_NUM_SRC 14
`define ROS_NUM_FLAGS 8

// Status register field positions.
`define ROS_ST_RELAY_BIT 0
`define ROS_ST_EXHAUST_BIT 1
`define ROS_ST_NOAUTO_BIT 2
`define ROS_ST_COUNT_LSB 4
`define ROS_ST_SEL_LSB 12

// Reset values.
`define ROS_RST_SOURCE 4'h0
`define ROS_RST_LEVEL 16'h0000
`define ROS_RST_TRIES 4'h0
`define ROS_RST_CMD 16'h0000

// Source selection codes.
`define ROS_SRC_OFF 4'h0
`define ROS_SRC_AT_SPEED 4'h1
`define ROS_SRC_MOTOR_POWERED 4'h2
`define ROS_SRC_REVERSE 4'h3
`define ROS_SRC_OVERLOAD 4'h4
`define ROS_SRC_RAMP_REG 4'h5
`define ROS_SRC_FREQ_OVER 4'h6
`define ROS_SRC_CURR_OVER 4'h7
`define ROS_SRC_BUS_VOLT_OVER 4'h8
`define ROS_SRC_RETRIES_EXHAUSTED 4'h9
`define ROS_SRC_ANALOG_OVER 4'ha
`define ROS_SRC_NETWORK_DIRECT 4'hb
`define ROS_SRC_UNRECOVERABLE 4'hc
`define ROS_SRC_LOGIC_CMD 4'hd

`endif

// File: ros_sync.v
// Two-flop synchroniser bank for asynchronous status flags.
module ros_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Flags
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
      // The first stage feeds only the second, so metastability never reaches logic.
      always @(posedge clk_i) begin
        if (rst_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign sync_o = stage2;

endmodule

// File: ros_relay_select.v
// Relay output source select with Wishbone register access.
`include "ros_consts.vh"

module ros_relay_select (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`ROS_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Drive status flags, asynchronous to clk_i
  input wire at_speed_i,
  input wire motor_powered_i,
  input wire reverse_cmd_i,
  input wire overload_i,
  input wire ramp_reg_active_i,
  input wire unrecoverable_fault_i,
  input wire restart_attempt_i,
  input wire restart_clear_i,
  // Measurements from logic on clk_i
  input wire [`ROS_MEAS_W-1:0] out_freq_hz_i,
  input wire [`ROS_MEAS_W-1:0] out_current_pct_i,
  input wire [`ROS_MEAS_W-1:0] bus_volt_i,
  input wire [`ROS_MEAS_W-1:0] analog_in_i,
  // Relay coil driver
  output reg relay_o
);

  // Software-visible settings.
  reg [`ROS_SEL_W-1:0] source_sel;
  reg [`ROS_LEVEL_W-1:0] relay_threshold_param;
  reg [`ROS_TRIES_W-1:0] restart_attempt_param;
  reg [`ROS_CMD_W-1:0] logic_cmd;

  // Restart bookkeeping.
  reg [`ROS_TRIES_W:0] attempt_count;
  reg attempt_seen;
  reg clear_seen;

  // Synchronised flags.
  wire [`ROS_NUM_FLAGS-1:0] flags_async;
  wire [`ROS_NUM_FLAGS-1:0] flags;
  wire sel_at_speed;
  wire sel_motor_powered;
  wire reverse_cmd;
  wire overload;
  wire ramp_reg_active;
  wire unrecoverable_fault;
  wire attempt_lvl;
  wire clear_lvl;
  wire attempt_pulse;
  wire clear_pulse;

  // Source conditions.
  wire freq_over_level;
  wire curr_over_level;
  wire sel_bus_volt_over_level;
  wire analog_over_level;
  wire retries_exhausted;
  wire auto_restart_disabled;
  wire sel_unrecoverable_fault;
  wire sel_network_direct;
  wire logic_cmd_relay;
  wire [`ROS_NUM_SRC-1:0] source_active;
  reg next_relay;

  // Bus decode.
  wire bus_req;
  wire bus_wr;
  wire hit_source;
  wire hit_level;
  wire hit_restart;
  wire hit_cmd;
  wire hit_status;
  wire hit_active;
  reg [31:0] next_rdata;

  assign flags_async = {restart_clear_i, restart_attempt_i, unrecoverable_fault_i,
                        ramp_reg_active_i, overload_i, reverse_cmd_i,
                        motor_powered_i, at_speed_i};

  ros_sync #(
    .WIDTH(`ROS_NUM_FLAGS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(flags_async),
    .sync_o(flags)
  );

  assign sel_at_speed = flags[0];
  assign sel_motor_powered = flags[1];
  assign reverse_cmd = flags[2];
  assign overload = flags[3];
  assign ramp_reg_active = flags[4];
  assign unrecoverable_fault = flags[5];
  assign attempt_lvl = flags[6];
  assign clear_lvl = flags[7];

  // Edge detectors look only at the second synchroniser stage.
  always @(posedge clk_i) begin
    if (rst_i) begin
      attempt_seen <= 1'b0;
      clear_seen <= 1'b0;
    end else begin
      attempt_seen <= attempt_lvl;
      clear_seen <= clear_lvl;
    end
  end

  assign attempt_pulse = attempt_lvl & ~attempt_seen;
  assign clear_pulse = clear_lvl & ~clear_seen;

  // The count saturates at all ones, well past the widest setting, so exhaustion can always be seen.
  // A new attempt in the same cycle as a clear is kept, so it is not lost.
  always @(posedge clk_i) begin
    if (rst_i) begin
      attempt_count <= {(`ROS_TRIES_W+1){1'b0}};
    end else if (attempt_pulse) begin
      if (clear_pulse) begin
        attempt_count <= {{`ROS_TRIES_W{1'b0}}, 1'b1};
      end else if (attempt_count != {(`ROS_TRIES_W+1){1'b1}}) begin
        attempt_count <= attempt_count + {{`ROS_TRIES_W{1'b0}}, 1'b1};
      end
    end else if (clear_pulse) begin
      attempt_count <= {(`ROS_TRIES_W+1){1'b0}};
    end
  end

  // Threshold comparisons share the one level setting.
  assign freq_over_level = out_freq_hz_i > relay_threshold_param;
  assign curr_over_level = out_current_pct_i > relay_threshold_param;
  assign sel_bus_volt_over_level = bus_volt_i > relay_threshold_param;
  assign analog_over_level = analog_in_i > relay_threshold_param;

  assign retries_exhausted = attempt_count > {1'b0, restart_attempt_param};
  assign auto_restart_disabled = restart_attempt_param == `ROS_RST_TRIES;
  assign sel_unrecoverable_fault = retries_exhausted | auto_restart_disabled |
                                   unrecoverable_fault;
  // Only the two defined values are honoured; any other level leaves the relay off.
  assign sel_network_direct = relay_threshold_param == {{(`ROS_LEVEL_W-1){1'b0}}, 1'b1};
  assign logic_cmd_relay = logic_cmd[`ROS_CMD_RELAY_BIT];

  assign source_active = {logic_cmd_relay, sel_unrecoverable_fault, sel_network_direct,
                          analog_over_level, retries_exhausted, sel_bus_volt_over_level,
                          curr_over_level, freq_over_level, ramp_reg_active, overload,
                          reverse_cmd, sel_motor_powered, sel_at_speed, 1'b0};

  always @* begin
    case (source_sel)
      `ROS_SRC_OFF: begin
        next_relay = 1'b0;
      end
      `ROS_SRC_AT_SPEED: begin
        next_relay = sel_at_speed;
      end
      `ROS_SRC_MOTOR_POWERED: begin
        next_relay = sel_motor_powered;
      end
      `ROS_SRC_REVERSE: begin
        next_relay = reverse_cmd;
      end
      `ROS_SRC_OVERLOAD: begin
        next_relay = overload;
      end
      `ROS_SRC_RAMP_REG: begin
        next_relay = ramp_reg_active;
      end
      `ROS_SRC_FREQ_OVER: begin
        next_relay = freq_over_level;
      end
      `ROS_SRC_CURR_OVER: begin
        next_relay = curr_over_level;
      end
      `ROS_SRC_BUS_VOLT_OVER: begin
        next_relay = sel_bus_volt_over_level;
      end
      `ROS_SRC_RETRIES_EXHAUSTED: begin
        next_relay = retries_exhausted;
      end
      `ROS_SRC_ANALOG_OVER: begin
        next_relay = analog_over_level;
      end
      `ROS_SRC_NETWORK_DIRECT: begin
        next_relay = sel_network_direct;
      end
      `ROS_SRC_UNRECOVERABLE: begin
        next_relay = sel_unrecoverable_fault;
      end
      `ROS_SRC_LOGIC_CMD: begin
        next_relay = logic_cmd_relay;
      end
      default: begin
        next_relay = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_o <= 1'b0;
    end else begin
      relay_o <= next_relay;
    end
  end

  // Classic Wishbone: one wait state, ack for exactly one cycle per request.
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & ~wb_ack_o;
  assign hit_source = wb_adr_i == `ROS_OFF_SOURCE;
  assign hit_level = wb_adr_i == `ROS_OFF_LEVEL;
  assign hit_restart = wb_adr_i == `ROS_OFF_RESTART;
  assign hit_cmd = wb_adr_i == `ROS_OFF_LOGIC_CMD;
  assign hit_status = wb_adr_i == `ROS_OFF_STATUS;
  assign hit_active = wb_adr_i == `ROS_OFF_ACTIVE;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      source_sel <= `ROS_RST_SOURCE;
    end else if (bus_wr && hit_source && wb_sel_i[0]) begin
      source_sel <= wb_dat_i[`ROS_SEL_W-1:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_threshold_param <= `ROS_RST_LEVEL;
    end else if (bus_wr && hit_level) begin
      if (wb_sel_i[0]) begin
        relay_threshold_param[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        relay_threshold_param[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      restart_attempt_param <= `ROS_RST_TRIES;
    end else if (bus_wr && hit_restart && wb_sel_i[0]) begin
      restart_attempt_param <= wb_dat_i[`ROS_TRIES_W-1:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      logic_cmd <= `ROS_RST_CMD;
    end else if (bus_wr && hit_cmd) begin
      if (wb_sel_i[0]) begin
        logic_cmd[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        logic_cmd[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Unmapped addresses are acknowledged, read as zero and ignore writes.
  always @* begin
    next_rdata = 32'h00000000;
    if (hit_source) begin
      next_rdata[`ROS_SEL_W-1:0] = source_sel;
    end else if (hit_level) begin
      next_rdata[`ROS_LEVEL_W-1:0] = relay_threshold_param;
    end else if (hit_restart) begin
      next_rdata[`ROS_TRIES_W-1:0] = restart_attempt_param;
    end else if (hit_cmd) begin
      next_rdata[`ROS_CMD_W-1:0] = logic_cmd;
    end else if (hit_status) begin
      next_rdata[`ROS_ST_RELAY_BIT] = relay_o;
      next_rdata[`ROS_ST_EXHAUST_BIT] = retries_exhausted;
      next_rdata[`ROS_ST_NOAUTO_BIT] = auto_restart_disabled;
      next_rdata[`ROS_ST_COUNT_LSB+`ROS_TRIES_W:`ROS_ST_COUNT_LSB] = attempt_count;
      next_rdata[`ROS_ST_SEL_LSB+`ROS_SEL_W-1:`ROS_ST_SEL_LSB] = source_sel;
    end else if (hit_active) begin
      next_rdata[`ROS_NUM_SRC-1:0] = source_active;
    end
  end

  // Read data is registered on the request edge and held until the next read request.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule

// File: ros_relay_select_properties.sv
// Port-level checker for the relay output source select block.
`include "ros_consts.vh"
module ros_relay_select_properties (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic overload_i,
  input logic [15:0] out_freq_hz_i,
  input logic [15:0] out_current_pct_i,
  input logic [15:0] bus_volt_i,
  input logic [15:0] analog_in_i,
  input logic relay_o
);
  logic [3:0] src;
  logic [15:0] lvl;
  logic cmd6;
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
  // Shadows follow bus writes so the overload, compare, network, command and off codes can be judged without seeing the body.
  always @(posedge clk_i) begin
    if (rst_i) begin
      src <= 4'h0;
      lvl <= 16'h0000;
      cmd6 <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == `ROS_OFF_SOURCE && wb_sel_i[0]) src <= wb_dat_i[3:0];
      if (wb_adr_i == `ROS_OFF_LEVEL && wb_sel_i[0]) lvl[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == `ROS_OFF_LEVEL && wb_sel_i[1]) lvl[15:8] <= wb_dat_i[15:8];
      if (wb_adr_i == `ROS_OFF_LOGIC_CMD && wb_sel_i[0]) cmd6 <= wb_dat_i[6];
    end
  end
  wire f_gt = out_freq_hz_i > lvl;
  wire c_gt = out_current_pct_i > lvl;
  wire v_gt = bus_volt_i > lvl;
  wire a_gt = analog_in_i > lvl;
  wire one = lvl == 16'h0001;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_off: assert property (disable iff (1'b0) rst_i |=> !relay_o)
    else $error("relay on after reset");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_overload_follow: assert property ((src == 4'h4)[*3] |=> relay_o == $past(overload_i, 3))
    else $error("relay does not follow overload");
  chk_freq_over: assert property (src == 4'h6 |=> relay_o == $past(f_gt))
    else $error("frequency compare wrong");
  chk_current_over: assert property (src == 4'h7 |=> relay_o == $past(c_gt))
    else $error("current compare wrong");
  chk_bus_volt: assert property (src == 4'h8 |=> relay_o == $past(v_gt))
    else $error("bus voltage compare wrong");
  chk_analog_over: assert property (src == 4'ha |=> relay_o == $past(a_gt))
    else $error("analog compare wrong");
  chk_network_level: assert property (src == 4'hb |=> relay_o == $past(one))
    else $error("network level not followed");
  chk_cmd_bit: assert property (src == 4'hd |=> relay_o == $past(cmd6))
    else $error("command bit not followed");
  chk_off_codes: assert property (src == 4'h0 || src > 4'hd |=> !relay_o)
    else $error("relay on with no source");
endmodule
bind ros_relay_select ros_relay_select_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .overload_i(overload_i),
  .out_freq_hz_i(out_freq_hz_i), .out_current_pct_i(out_current_pct_i),
  .bus_volt_i(bus_volt_i), .analog_in_i(analog_in_i), .relay_o(relay_o));

// File: ros_drive_model.sv
// Drive-side model: launches status flags on the clock and counts coil pull-ins.
module ros_drive_model (
  input logic clk_i,
  input logic [7:0] flags_i,
  input logic relay_i,
  output logic [7:0] flags_o,
  output logic [7:0] coil_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic relay_q;
  initial begin
    flags_o = 8'h00;
    relay_q = 1'b0;
    coil_count_o = 8'h00;
  end
  always @(posedge clk_i) begin
    flags_o <= flags_i;
    relay_q <= relay_i;
    if (relay_i && !relay_q) coil_count_o <= coil_count_o + 8'h01;
  end
endmodule

// File: ros_relay_select_tb_top.sv
// Self-checking bench for the relay output source select block.
`include "ros_consts.vh"
module ros_relay_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, relay;
  logic [7:0] adr = 8'h00, flags = 8'h00, fl, coils;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [15:0] meas [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  int errors = 0, comparisons = 0, cycles = 0;
  always #2.5 clk_i = ~clk_i;
  ros_drive_model u_ros_drive_model (.clk_i(clk_i), .flags_i(flags), .relay_i(relay),
    .flags_o(fl), .coil_count_o(coils));
  ros_relay_select u_ros_relay_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .at_speed_i(fl[0]), .motor_powered_i(fl[1]),
    .reverse_cmd_i(fl[2]), .overload_i(fl[3]), .ramp_reg_active_i(fl[4]),
    .unrecoverable_fault_i(fl[5]), .restart_attempt_i(fl[6]), .restart_clear_i(fl[7]),
    .out_freq_hz_i(meas[0]), .out_current_pct_i(meas[1]), .bus_volt_i(meas[2]),
    .analog_in_i(meas[3]), .relay_o(relay));
  task close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until ack is sampled, then takes read data at that edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task rl(input logic e);
    @(negedge clk_i);
    check({31'h0, relay}, {31'h0, e});
  endtask
  // Six edges cover the model stage, the two sync flops and the output register.
  task setf(input logic [7:0] v);
    @(posedge clk_i);
    flags <= v;
    repeat (6) @(posedge clk_i);
  endtask
  // The other three inputs sit at 16'hffff, above any lower level, so a wrong source shows up as a set relay.
  task setm(input int k, input logic [15:0] v);
    @(posedge clk_i);
    for (int j = 0; j < 4; j++) meas[j] <= (j == k) ? v : 16'hffff;
    @(posedge clk_i);
  endtask
  task t_regs;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0, 4'hf);
      check(q, 32'h0);
    end
    bus(1'b1, `ROS_OFF_LEVEL, 32'h1234, 4'h1);
    bus(1'b0, `ROS_OFF_LEVEL, 32'h0, 4'hf);
    check(q, 32'h34);
    wr(8'h20, 32'hffff);
    bus(1'b0, 8'h20, 32'h0, 4'hf);
    check(q, 32'h0);
  endtask
  task t_flags;
    for (int i = 1; i < 6; i++) begin
      wr(`ROS_OFF_SOURCE, i);
      setf(8'h3f & ~(8'h01 << (i - 1)));
      rl(1'b0);
      setf(8'h01 << (i - 1));
      rl(1'b1);
    end
    setf(8'h00);
  endtask
  task t_meas;
    logic [3:0] codes [4];
    codes = '{4'h6, 4'h7, 4'h8, 4'ha};
    wr(`ROS_OFF_LEVEL, 32'h0100);
    for (int k = 0; k < 4; k++) begin
      wr(`ROS_OFF_SOURCE, codes[k]);
      setm(k, 16'h0100);
      rl(1'b0);
      setm(k, 16'h0101);
      rl(1'b1);
    end
  endtask
  task t_net;
    logic [7:0] c0;
    wr(`ROS_OFF_SOURCE, 32'hb);
    c0 = coils;
    for (int v = 0; v < 3; v++) begin
      wr(`ROS_OFF_LEVEL, v);
      rl(v == 1);
    end
    check(coils - c0, 32'h1);
  endtask
  task t_cmd;
    wr(`ROS_OFF_SOURCE, 32'hd);
    wr(`ROS_OFF_LOGIC_CMD, 32'h0040);
    rl(1'b1);
    wr(`ROS_OFF_LOGIC_CMD, 32'hffbf);
    rl(1'b0);
  endtask
  task t_retry;
    wr(`ROS_OFF_RESTART, 32'h2);
    wr(`ROS_OFF_SOURCE, 32'h9);
    for (int n = 1; n < 4; n++) begin
      setf(8'h40);
      setf(8'h00);
      rl(n == 3);
    end
    bus(1'b0, `ROS_OFF_STATUS, 32'h0, 4'hf);
    check(q, (32'h9 << `ROS_ST_SEL_LSB) | (32'h3 << `ROS_ST_COUNT_LSB) | 32'h3);
    bus(1'b0, `ROS_OFF_ACTIVE, 32'h0, 4'hf);
    check(q, 32'h17c0);
    wr(`ROS_OFF_SOURCE, 32'hc);
    rl(1'b1);
    setf(8'h80);
    setf(8'h00);
    rl(1'b0);
    setf(8'h20);
    rl(1'b1);
    setf(8'h00);
    wr(`ROS_OFF_RESTART, 32'h0);
    rl(1'b1);
  endtask
  task t_off;
    setf(8'h3f);
    for (int c = 14; c < 16; c++) begin
      wr(`ROS_OFF_SOURCE, c);
      rl(1'b0);
    end
    wr(`ROS_OFF_SOURCE, 32'h4);
    rl(1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    repeat (2) rl(1'b0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    rl(1'b0);
    bus(1'b0, `ROS_OFF_LEVEL, 32'h0, 4'hf);
    check(q, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_flags;
    t_meas;
    t_net;
    t_cmd;
    t_retry;
    t_off;
    close_out;
  end
endmodule
